// File: rtl/pcsr_pkg.sv
// constants shared by the sublayer control register bank
// assumes a single 200 MHz core clock and an APB master with 32-bit data
//
// Notes on behaviour
// - scratch word reads back the low 16 bits software last wrote, per written byte lane; upper bits read zero.
// - version register is read-only with a fixed code; writes change nothing.
// - negotiation interval is 21 bits in 8 ns steps, zero up to 16 ms.
// - after reset the interval holds the count for 10 ms.
// - interval bits 15:0 sit in the low word; bit 0 is always zero.
// - interval bits 20:16 sit in the high word; other bits read zero.
// - interface kind register selects 1000BASE-X or SGMII, read and write.
// - control bit 13 reads 0 and bit 6 reads 1, gigabit only.
// - control bit 7 is read-only zero, no half duplex.
// - control bit 8 is read-only one, full duplex only.
// - writing one to control bit 9 restarts negotiation; resets to zero.
// - control bit 10 detaches the sublayer from the MAC side; resets zero.
// - control bit 11 drives the power-down output toward the transceiver.
// - control bit 12 enables negotiation and resets to one.
// - control bit 14 loops back in the PMA; ignored when RTBI built.
// - writing one to control bit 15 gives a self-clearing sync reset pulse.
// - control word sits at the first offset and is read and write.

package pcsr_pkg;

  // ==================================================
  // register indices, byte address is four times the index
  localparam int unsigned ADDR_W = 8;
  localparam logic [5:0] IDX_CONTROL = 6'h00;
  localparam logic [5:0] IDX_SCRATCH = 6'h20;
  localparam logic [5:0] IDX_VERSION = 6'h22;
  localparam logic [5:0] IDX_TIMER_LO = 6'h24;
  localparam logic [5:0] IDX_TIMER_HI = 6'h26;
  localparam logic [5:0] IDX_IF_KIND = 6'h28;

  // ==================================================
  // control word bit positions
  localparam int unsigned CTL_RESET = 15;
  localparam int unsigned CTL_LOOPBACK = 14;
  localparam int unsigned CTL_SPEED_MSB = 13;
  localparam int unsigned CTL_AN_ENABLE = 12;
  localparam int unsigned CTL_POWER_DOWN = 11;
  localparam int unsigned CTL_MAC_DETACH = 10;
  localparam int unsigned CTL_AN_RESTART = 9;
  localparam int unsigned CTL_DUPLEX = 8;
  localparam int unsigned CTL_HALF_PROBE = 7;
  localparam int unsigned CTL_SPEED_LSB = 6;

  // ==================================================
  // values after reset
  localparam logic CTL_AN_ENABLE_RESET = 1'b1;
  localparam logic CTL_LOOPBACK_RESET = 1'b0;
  localparam logic CTL_POWER_DOWN_RESET = 1'b0;
  localparam logic CTL_MAC_DETACH_RESET = 1'b0;
  localparam logic [15:0] SCRATCH_RESET = 16'h0000;
  localparam logic IF_KIND_BASEX = 1'b0;
  localparam logic IF_KIND_SGMII = 1'b1;
  localparam logic IF_KIND_RESET = IF_KIND_BASEX;

  // ==================================================
  // negotiation interval, counted in periods of the 125 MHz sublayer clock
  localparam int unsigned TIMER_W = 21;
  localparam int unsigned TIMER_STEP_NS = 8;
  localparam int unsigned TIMER_SPAN_MS = 16;
  localparam int unsigned TIMER_RESET_MS = 10;
  localparam int unsigned TIMER_RESET_NS = TIMER_RESET_MS * 1000000;
  localparam logic [20:0] TIMER_RESET_COUNT = 21'(TIMER_RESET_NS / TIMER_STEP_NS);

  // ==================================================
  // pulse timing on the 200 MHz core clock, least times round up
  localparam int unsigned CORE_CLK_PS = 5000;
  localparam int unsigned SYNC_RESET_NS = 20;
  localparam int unsigned SYNC_RESET_CYCLES = (SYNC_RESET_NS * 1000 + CORE_CLK_PS - 1) / CORE_CLK_PS;
  localparam int unsigned RESTART_CYCLES = 1;

endpackage

// File: rtl/pcsr_pulse.sv
// self-clearing command bit: one write starts a pulse of fixed length
// assumes fire comes from logic on core_clk
`timescale 1ns/1ps

module pcsr_pulse #(
  parameter int unsigned LEN = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // command and pulse
  input wire logic fire,
  output logic active
);

  typedef struct packed {
    logic on;
    logic [7:0] left;
  } pcsr_pulse_t;

  pcsr_pulse_t st;
  pcsr_pulse_t next_st;

  // ==================================================
  // a fire while busy is dropped so the pulse length stays exact
  always_comb
  begin
    next_st = st;
    if (fire && !st.on)
    begin
      next_st.on = 1'b1;
      next_st.left = 8'(LEN - 1);
    end
    else if (st.left != 8'h00)
    begin
      next_st.left = st.left - 8'h01;
    end
    else
    begin
      next_st.on = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign active = st.on;

  a_pulse_start: assert property (@(posedge core_clk) disable iff (!reset_n)
    fire && !active |=> active)
    else $error("pulse did not start after fire");

endmodule

// File: rtl/pcsr_regs.sv
// control register bank of the gigabit physical coding sublayer
// assumes an APB master on core_clk; the bits drive negotiation, coding
// and transceiver logic outside this block
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps

module pcsr_regs #(
  // arbitrary revision value of our own
  parameter logic [15:0] VERSION_CODE = 16'h5A3C,
  // set when the reduced ten-bit interface is built
  parameter bit RTBI_BUILT = 1'b0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // controls toward the sublayer
  output logic an_restart,
  output logic an_enable,
  output logic mac_detach,
  output logic power_down,
  output logic pma_loopback,
  output logic sublayer_sync_reset,
  output logic interface_sgmii,
  output logic [20:0] negotiation_interval
);

  typedef struct packed {
    logic [15:0] scratch;
    logic [20:1] timer;
    logic if_kind;
    logic loopback;
    logic an_en;
    logic pwr_down;
    logic detach;
    logic [31:0] rdata;
    logic slverr;
  } pcsr_state_t;

  pcsr_state_t st;
  pcsr_state_t next_st;

  logic setup_phase;
  logic wr_access;
  logic [5:0] idx;
  logic addr_ok;
  logic wr_ctl;
  logic restart_fire;
  logic reset_fire;
  logic restart_busy;
  logic reset_busy;
  logic [15:0] ctl_read;
  logic [15:0] ctl_new;
  logic [15:0] lo_new;
  logic [15:0] hi_new;
  logic [15:0] rd_word;

  // ==================================================
  // helpers
  function automatic logic idx_mapped(input logic [7:0] addr);
    logic hit;
    hit = 1'b0;
    if (addr[1:0] == 2'h0)
    begin
      unique case (addr[7:2])
        pcsr_pkg::IDX_CONTROL,
        pcsr_pkg::IDX_SCRATCH,
        pcsr_pkg::IDX_VERSION,
        pcsr_pkg::IDX_TIMER_LO,
        pcsr_pkg::IDX_TIMER_HI,
        pcsr_pkg::IDX_IF_KIND: hit = 1'b1;
        default: hit = 1'b0;
      endcase
    end
    return hit;
  endfunction

  // only the two low byte lanes carry register bits
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] wdata,
                                             input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0])
    begin
      res[7:0] = wdata[7:0];
    end
    if (strb[1])
    begin
      res[15:8] = wdata[15:8];
    end
    return res;
  endfunction

  // ==================================================
  // apb phases: read data is caught in the setup cycle so prdata comes
  // from a flop, at the price of one fixed wait-free access phase
  assign setup_phase = psel && !penable;
  assign wr_access = psel && penable && pwrite;
  assign idx = paddr[7:2];
  assign addr_ok = idx_mapped(paddr);
  assign pready = psel && penable;
  assign pslverr = psel && penable && st.slverr;
  assign prdata = st.rdata;

  // ==================================================
  // control word as software sees it
  always_comb
  begin
    ctl_read = 16'h0000;
    ctl_read[pcsr_pkg::CTL_RESET] = reset_busy;
    ctl_read[pcsr_pkg::CTL_LOOPBACK] = st.loopback;
    ctl_read[pcsr_pkg::CTL_SPEED_MSB] = 1'b0;
    ctl_read[pcsr_pkg::CTL_AN_ENABLE] = st.an_en;
    ctl_read[pcsr_pkg::CTL_POWER_DOWN] = st.pwr_down;
    ctl_read[pcsr_pkg::CTL_MAC_DETACH] = st.detach;
    ctl_read[pcsr_pkg::CTL_AN_RESTART] = restart_busy;
    ctl_read[pcsr_pkg::CTL_DUPLEX] = 1'b1;
    ctl_read[pcsr_pkg::CTL_HALF_PROBE] = 1'b0;
    ctl_read[pcsr_pkg::CTL_SPEED_LSB] = 1'b1;
  end

  // ==================================================
  // read mux
  always_comb
  begin
    rd_word = 16'h0000;
    unique case (idx)
      pcsr_pkg::IDX_CONTROL: rd_word = ctl_read;
      pcsr_pkg::IDX_SCRATCH: rd_word = st.scratch;
      pcsr_pkg::IDX_VERSION: rd_word = VERSION_CODE;
      pcsr_pkg::IDX_TIMER_LO: rd_word = {st.timer[15:1], 1'b0};
      pcsr_pkg::IDX_TIMER_HI: rd_word = {11'h000, st.timer[20:16]};
      pcsr_pkg::IDX_IF_KIND: rd_word = {15'h0000, st.if_kind};
      default: rd_word = 16'h0000;
    endcase
    if (!addr_ok)
    begin
      rd_word = 16'h0000;
    end
  end

  // ==================================================
  // write decode
  assign wr_ctl = wr_access && addr_ok && (idx == pcsr_pkg::IDX_CONTROL);
  assign ctl_new = lane_merge(ctl_read, pwdata, pstrb);
  assign lo_new = lane_merge({st.timer[15:1], 1'b0}, pwdata, pstrb);
  assign hi_new = lane_merge({11'h000, st.timer[20:16]}, pwdata, pstrb);
  // command bits fire only when their own byte lane is written
  assign restart_fire = wr_ctl && pstrb[1] && pwdata[pcsr_pkg::CTL_AN_RESTART];
  assign reset_fire = wr_ctl && pstrb[1] && pwdata[pcsr_pkg::CTL_RESET];

  // ==================================================
  // next state
  always_comb
  begin
    next_st = st;
    if (setup_phase)
    begin
      next_st.rdata = pwrite ? 32'h0000_0000 : {16'h0000, rd_word};
      next_st.slverr = !addr_ok;
    end
    if (wr_access && addr_ok)
    begin
      unique case (idx)
        pcsr_pkg::IDX_CONTROL:
        begin
          // fixed and reserved bits are simply not stored
          next_st.loopback = ctl_new[pcsr_pkg::CTL_LOOPBACK];
          next_st.an_en = ctl_new[pcsr_pkg::CTL_AN_ENABLE];
          next_st.pwr_down = ctl_new[pcsr_pkg::CTL_POWER_DOWN];
          next_st.detach = ctl_new[pcsr_pkg::CTL_MAC_DETACH];
        end
        pcsr_pkg::IDX_SCRATCH:
        begin
          next_st.scratch = lane_merge(st.scratch, pwdata, pstrb);
        end
        pcsr_pkg::IDX_TIMER_LO:
        begin
          next_st.timer[15:1] = lo_new[15:1];
        end
        pcsr_pkg::IDX_TIMER_HI:
        begin
          next_st.timer[20:16] = hi_new[4:0];
        end
        pcsr_pkg::IDX_IF_KIND:
        begin
          next_st.if_kind = lane_merge({15'h0000, st.if_kind}, pwdata, pstrb) != 16'h0000 &&
                            pwdata[0] == pcsr_pkg::IF_KIND_SGMII && pstrb[0] ? pcsr_pkg::IF_KIND_SGMII :
                            (pstrb[0] ? pcsr_pkg::IF_KIND_BASEX : st.if_kind);
        end
        default:
        begin
          next_st.scratch = st.scratch;
        end
      endcase
    end
  end

  // ==================================================
  // state register
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st.scratch <= pcsr_pkg::SCRATCH_RESET;
      st.timer <= pcsr_pkg::TIMER_RESET_COUNT[20:1];
      st.if_kind <= pcsr_pkg::IF_KIND_RESET;
      st.loopback <= pcsr_pkg::CTL_LOOPBACK_RESET;
      st.an_en <= pcsr_pkg::CTL_AN_ENABLE_RESET;
      st.pwr_down <= pcsr_pkg::CTL_POWER_DOWN_RESET;
      st.detach <= pcsr_pkg::CTL_MAC_DETACH_RESET;
      st.rdata <= 32'h0000_0000;
      st.slverr <= 1'b0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ==================================================
  // self-clearing command pulses
  pcsr_pulse #(
    .LEN(pcsr_pkg::RESTART_CYCLES)
  ) u_restart (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .fire(restart_fire),
    .active(restart_busy)
  );

  pcsr_pulse #(
    .LEN(pcsr_pkg::SYNC_RESET_CYCLES)
  ) u_sync_reset (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .fire(reset_fire),
    .active(reset_busy)
  );

  // ==================================================
  // outputs
  assign an_restart = restart_busy;
  assign sublayer_sync_reset = reset_busy;
  assign an_enable = st.an_en;
  assign mac_detach = st.detach;
  assign power_down = st.pwr_down;
  // loopback cannot be built around the reduced ten-bit interface
  assign pma_loopback = st.loopback && !RTBI_BUILT;
  assign interface_sgmii = st.if_kind;
  assign negotiation_interval = {st.timer, 1'b0};

  // ==================================================
  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  a_scratch_echo: assert property (
    wr_access && addr_ok && idx == pcsr_pkg::IDX_SCRATCH && pstrb[1:0] == 2'h3
    |=> st.scratch == $past(pwdata[15:0]))
    else $error("scratch did not store written word");

  a_version_fixed: assert property (
    setup_phase && !pwrite && paddr == {pcsr_pkg::IDX_VERSION, 2'h0}
    |=> prdata == {16'h0000, VERSION_CODE})
    else $error("version read wrong");

  a_timer_reset: assert property (
    $rose(reset_n) |-> negotiation_interval == pcsr_pkg::TIMER_RESET_COUNT)
    else $error("interval reset value wrong");

  a_timer_low_write: assert property (
    wr_access && addr_ok && idx == pcsr_pkg::IDX_TIMER_LO && pstrb[1:0] == 2'h3
    |=> negotiation_interval[15:0] == {$past(pwdata[15:1]), 1'b0})
    else $error("interval low word write wrong");

  a_timer_high_read: assert property (
    setup_phase && !pwrite && paddr == {pcsr_pkg::IDX_TIMER_HI, 2'h0}
    |=> prdata[31:5] == 27'h0 && prdata[4:0] == $past(negotiation_interval[20:16]))
    else $error("interval high word read wrong");

  a_ctl_fixed: assert property (
    setup_phase && !pwrite && paddr == {pcsr_pkg::IDX_CONTROL, 2'h0}
    |=> prdata[13] == 1'b0 && prdata[8:6] == 3'h5 && prdata[5:0] == 6'h00)
    else $error("fixed control bits wrong");

  a_restart_once: assert property (
    restart_fire |=> an_restart ##1 !an_restart)
    else $error("restart pulse not one cycle");

  a_sync_reset_len: assert property (
    reset_fire && !sublayer_sync_reset |=> sublayer_sync_reset [*4] ##1 !sublayer_sync_reset)
    else $error("sync reset pulse length wrong");

  a_power_down_follow: assert property (
    wr_ctl && pstrb[1] |=> power_down == $past(pwdata[11]))
    else $error("power down not following write");

  a_loopback_follow: assert property (
    wr_ctl && pstrb[1] |=> pma_loopback == ($past(pwdata[pcsr_pkg::CTL_LOOPBACK]) && !RTBI_BUILT))
    else $error("loopback not following write");

  a_detach_follow: assert property (
    wr_ctl && pstrb[1] |=> mac_detach == $past(pwdata[pcsr_pkg::CTL_MAC_DETACH]))
    else $error("detach not following write");

  a_an_enable_follow: assert property (
    wr_ctl && pstrb[1] |=> an_enable == $past(pwdata[pcsr_pkg::CTL_AN_ENABLE]))
    else $error("negotiation enable not following write");

  a_kind_select: assert property (
    wr_access && addr_ok && idx == pcsr_pkg::IDX_IF_KIND && pstrb[0]
    |=> interface_sgmii == $past(pwdata[0]))
    else $error("interface kind not following write");

  a_timer_high_write: assert property (
    wr_access && addr_ok && idx == pcsr_pkg::IDX_TIMER_HI && pstrb[0]
    |=> negotiation_interval[20:16] == $past(pwdata[4:0]))
    else $error("interval high word write wrong");

  a_sync_reset_read: assert property (
    sublayer_sync_reset && setup_phase && !pwrite && paddr == {pcsr_pkg::IDX_CONTROL, 2'h0}
    |=> prdata[pcsr_pkg::CTL_RESET] == 1'b1)
    else $error("reset bit not shown while pulse runs");

  a_unmapped_err: assert property (
    setup_phase && !addr_ok |=> pslverr == (psel && penable) && prdata == 32'h0000_0000)
    else $error("unmapped address not refused");

  // a refused write must not leak into the scratch, timer or interface kind register
  a_unmapped_keep: assert property (
    wr_access && !addr_ok |=> $stable(st.scratch) && $stable(st.timer) && $stable(st.if_kind))
    else $error("refused write changed a register");

endmodule

// File: test/tb_pcsr_regs.sv
// self-checking bench for the sublayer control register bank
// assumes the bank drives its controls from flops; the master waits for pready
`timescale 1ns/1ps
`define CHK(what, exp, got) \
  begin \
    n_checks = n_checks + 1; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch = n_mismatch + 1; \
      $display("mismatch %s expected %h seen %h", what, exp, got); \
    end \
  end

module tb_pcsr_regs;
  // ==================================================
  // constants
  // arbitrary revision value of our own
  localparam logic [15:0] VER = 16'h3C96;
  localparam logic [7:0] A_CTL = 8'h00;
  localparam logic [7:0] A_SCR = 8'h80;
  localparam logic [7:0] A_VER = 8'h88;
  localparam logic [7:0] A_TLO = 8'h90;
  localparam logic [7:0] A_THI = 8'h98;
  localparam logic [7:0] A_KIND = 8'hA0;
  localparam logic [20:0] T_RST = 21'(10000000 / 8);

  // ==================================================
  // signals
  logic core_clk;
  logic reset_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic an_restart;
  logic an_enable;
  logic mac_detach;
  logic power_down;
  logic pma_loopback;
  logic sublayer_sync_reset;
  logic interface_sgmii;
  logic [20:0] negotiation_interval;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_restart = 0;
  int n_sync = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h00007C6F;

  pcsr_regs #(.VERSION_CODE(VER), .RTBI_BUILT(1'b0)) pcsr_regs_i (
    .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .an_restart(an_restart), .an_enable(an_enable), .mac_detach(mac_detach),
    .power_down(power_down), .pma_loopback(pma_loopback), .sublayer_sync_reset(sublayer_sync_reset),
    .interface_sgmii(interface_sgmii), .negotiation_interval(negotiation_interval));

  // ==================================================
  // clock, pulse counters and hang guard
  initial core_clk = 1'b0;
  always #2.5 core_clk = ~core_clk;

  always @(posedge core_clk)
  begin
    cycles = cycles + 1;
    if (an_restart === 1'b1)
      n_restart = n_restart + 1;
    if (sublayer_sync_reset === 1'b1)
      n_sync = n_sync + 1;
    if (cycles == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      complete_run();
    end
  end

  // ==================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // fixed gigabit and full-duplex bits plus the writable ones
  function automatic logic [32:0] ctl_exp(input logic [31:0] w);
    return {17'h00000, (w[15:0] & 16'h5C00) | 16'h0140};
  endfunction

  // one APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    // only the bench's hang guard ends a wait that never sees pready
    while (pready !== 1'b1)
    begin
      @(posedge core_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic put(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask

  // error flag returned above the data so one compare covers both
  task automatic get(input logic [7:0] a, output logic [32:0] r);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h00000000, rd, err);
    r = {err, rd};
  endtask

  task automatic complete_run();
    if (n_mismatch == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ==================================================
  // main sequence
  initial
  begin
    logic [31:0] w;
    logic [31:0] x;
    logic [32:0] r;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    `CHK("an_enable", 1'b1, an_enable)
    `CHK("controls", 5'h00, {an_restart, mac_detach, power_down, pma_loopback, sublayer_sync_reset})
    `CHK("interval", T_RST, negotiation_interval)
    `CHK("sgmii", 1'b0, interface_sgmii)
    get(A_CTL, r);
    `CHK("control", 33'h000001140, r)
    get(A_TLO, r);
    `CHK("timer low", {17'h00000, T_RST[15:0]}, r)
    get(A_THI, r);
    `CHK("timer high", {28'h0000000, T_RST[20:16]}, r)
    // version ignores writes
    put(A_VER, {16'hFFFF, ~VER});
    get(A_VER, r);
    `CHK("version", {17'h00000, VER}, r)
    for (int i = 0; i < 8; i++)
    begin
      w = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h00000000 : rnd();
      put(A_SCR, w);
      get(A_SCR, r);
      `CHK("scratch", {17'h00000, w[15:0]}, r)
    end
    // timer halves, corners first
    for (int i = 0; i < 8; i++)
    begin
      w = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h00000000 : rnd();
      x = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h00000000 : rnd();
      put(A_TLO, w);
      put(A_THI, x);
      get(A_TLO, r);
      `CHK("timer low", {17'h00000, w[15:0] & 16'hFFFE}, r)
      get(A_THI, r);
      `CHK("timer high", {28'h0000000, x[4:0]}, r)
      `CHK("interval", {x[4:0], w[15:1], 1'b0}, negotiation_interval)
    end
    for (int i = 0; i < 4; i++)
    begin
      w = rnd();
      w[0] = i[0];
      put(A_KIND, w);
      get(A_KIND, r);
      `CHK("kind", {32'h00000000, w[0]}, r)
      `CHK("sgmii", w[0], interface_sgmii)
    end
    // control word with the self-clearing bits held off
    for (int i = 0; i < 12; i++)
    begin
      w = (i == 0) ? 32'hFFFF7DFF : (i == 1) ? 32'h00000000 : (rnd() & 32'hFFFF7DFF);
      put(A_CTL, w);
      get(A_CTL, r);
      `CHK("control", ctl_exp(w), r)
      `CHK("levels", {w[12], w[10], w[11], w[14]}, {an_enable, mac_detach, power_down, pma_loopback})
    end
    // two restarts in a row give two single-cycle pulses
    put(A_CTL, 32'h00001000);
    n_restart = 0;
    put(A_CTL, 32'h00001200);
    put(A_CTL, 32'h00001200);
    repeat (8) @(posedge core_clk);
    `CHK("restart pulses", 2, n_restart)
    get(A_CTL, r);
    `CHK("control", 33'h000001140, r)
    // a second reset request inside the running pulse must not stretch it
    n_sync = 0;
    put(A_CTL, 32'h00009000);
    put(A_CTL, 32'h00009000);
    repeat (8) @(posedge core_clk);
    `CHK("sync reset cycles", int'(pcsr_pkg::SYNC_RESET_CYCLES), n_sync)
    get(A_CTL, r);
    `CHK("control", 33'h000001140, r)
    // the reset bit reads one while its pulse still runs
    put(A_CTL, 32'h00009000);
    get(A_CTL, r);
    `CHK("control busy", 33'h000009140, r)
    // unmapped and misaligned places refuse and leave the scratch word alone
    put(A_SCR, 32'h0000A55A);
    put(8'h84, 32'h00001234);
    put(8'h82, 32'h00004321);
    get(8'h84, r);
    `CHK("unmapped", 33'h100000000, r)
    get(8'h81, r);
    `CHK("misaligned", 33'h100000000, r)
    get(A_SCR, r);
    `CHK("scratch", 33'h00000A55A, r)
    // a reset in mid-run brings the bank back to its values after reset
    put(A_CTL, 32'h00004C00);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    `CHK("levels", 5'h10, {an_enable, mac_detach, power_down, pma_loopback, interface_sgmii})
    `CHK("interval", T_RST, negotiation_interval)
    get(A_SCR, r);
    `CHK("scratch", {17'h00000, pcsr_pkg::SCRATCH_RESET}, r)
    complete_run();
  end
endmodule
